// ===== twsl_map.svh
// Purpose: Register offsets, field positions, reset values and status codes.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef TWSL_MAP_SVH
`define TWSL_MAP_SVH
// --------------------------------------------------------------------------
// Register byte offsets.
// --------------------------------------------------------------------------
`define TWSL_OFF_ADDR 12'h000
`define TWSL_OFF_CTRL 12'h004
`define TWSL_OFF_STAT 12'h008
`define TWSL_OFF_DATA 12'h00C
`define TWSL_OFF_IRQS 12'h010
`define TWSL_OFF_IRQM 12'h014
// --------------------------------------------------------------------------
// Control field positions.
// --------------------------------------------------------------------------
`define TWSL_CTL_FLAG 7
`define TWSL_CTL_ACK 6
`define TWSL_CTL_STA 5
`define TWSL_CTL_STO 4
`define TWSL_CTL_WCOL 3
`define TWSL_CTL_EN 2
`define TWSL_CTL_SLEEP 1
`define TWSL_CTL_IE 0
// --------------------------------------------------------------------------
// Reset values and status codes.
// --------------------------------------------------------------------------
`define TWSL_RST_ADDR 8'h00
`define TWSL_RST_CTRL 8'h00
`define TWSL_ST_STOP 8'hA0
`define TWSL_ST_SLAR 8'hA8
`define TWSL_ST_ARBR 8'hB0
`define TWSL_ST_DACK 8'hB8
`define TWSL_ST_DNAK 8'hC0
`define TWSL_ST_LACK 8'hC8
`define TWSL_ST_SLAW 8'h60
`define TWSL_ST_GCW 8'h70
`define TWSL_ST_NONE 8'hF8
`define TWSL_GC_ADDR 7'h00
`endif

// ===== twsl_pkg.sv
// Purpose: Types shared by the two-wire slave transmitter.
// Assumes: Included map header for numeric values.
// Notes: Holds only types.
package twsl_pkg;
    // Bit engine states.
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, // Not addressed, watching the bus.
        S_ADDR = 3'b001, // Shifting in the address byte.
        S_AACK = 3'b010, // Driving the address acknowledge.
        S_HOLD = 3'b011, // Clock stretched until software serves.
        S_TXB = 3'b100, // Shifting out a data byte.
        S_RACK = 3'b101, // Sampling the master acknowledge.
        S_RX = 3'b110, // Receive side, not detailed here.
        S_LAST = 3'b111 // Past the final byte, sending ones.
    } twsl_state_t;
    // Edge events found on the synchronised bus lines.
    typedef struct packed {
        logic scl_rise; // Clock rising edge.
        logic scl_fall; // Clock falling edge.
        logic start; // Start or repeated start.
        logic stop; // Stop condition.
        logic sda; // Settled data level.
    } twsl_bus_ev_t;
endpackage : twsl_pkg

// ===== twsl_sync.sv
// Purpose: Synchronise both bus lines and find edges and start or stop.
// Assumes: Lines come from outside the CLK domain.
// Notes: First stage read only by the second stage.
`timescale 1ns/10ps
module twsl_sync (
    input wire logic CLK, // System clock.
    input wire logic RST, // Asynchronous reset, active high.
    input wire logic scl_i, // Raw clock line.
    input wire logic sda_i, // Raw data line.
    output twsl_pkg::twsl_bus_ev_t ev // Decoded bus events.
);
    // All state in one struct, idle bus is high.
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } twsl_sync_st_t;
    twsl_sync_st_t st_ff;
    twsl_sync_st_t nxt_st;
    // --------------------------------------------------------------
    // Next state: shift the two-stage chain and keep a history stage.
    // --------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {scl_i, sda_i};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end
    // Register the state.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // Events use only the second and history stages.
    assign ev.scl_rise = st_ff.s2[1] & ~st_ff.s3[1];
    assign ev.scl_fall = ~st_ff.s2[1] & st_ff.s3[1];
    assign ev.start = st_ff.s2[1] & st_ff.s3[1] & ~st_ff.s2[0] & st_ff.s3[0];
    assign ev.stop = st_ff.s2[1] & st_ff.s3[1] & st_ff.s2[0] & ~st_ff.s3[0];
    assign ev.sda = st_ff.s2[0];
endmodule : twsl_sync

// ===== twsl_slave.sv
// Purpose: Slave transmitter side of a two-wire serial interface.
// Assumes: APB register access, bus lines sampled by CLK.
// Notes: Master and receive data paths are reduced to status reporting.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "twsl_map.svh"

// Overview of operation
// - Stop or restart while addressed reports A0
// - Match own address; general call if enabled
// - Read bit enters transmit, else receive
// - Address match sets flag with status
// - Status prescaler bits read as zero
// - A8 then load byte; ack-enable picks last
// - Lost arbitration then own read reports B0
// - Final byte reports C0 or C8
// - After final byte release data, send ones
// - Ack-enable zero ignores address, keeps watching
// - Sleep still matches address with ack-enable
// - Wake on a read match holds clock low until flag cleared
// - Data register may miss last byte
module twsl_slave (
    input wire logic CLK, // System clock, 100 MHz.
    input wire logic RST, // Asynchronous reset, active high.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB access phase.
    input wire logic PWRITE, // APB direction.
    input wire logic [11:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready, always one.
    output logic PSLVERR, // APB error on unmapped address.
    input wire logic ARB_LOST, // Own master lost arbitration, same clock.
    input wire logic SCL_I, // Bus clock line level.
    output logic SCL_OE, // High while pulling clock low.
    output logic SCL_O, // Clock drive value, always low.
    input wire logic SDA_I, // Bus data line level.
    output logic SDA_OE, // High while pulling data low.
    output logic SDA_O, // Data drive value, always low.
    output logic WAKE, // Wake request to the system.
    output logic IRQ // Level interrupt.
);
    // ----------------------------------------------------------------
    // State record.
    // ----------------------------------------------------------------
    typedef struct packed {
        twsl_pkg::twsl_state_t fsm; // Bit engine state.
        logic [7:0] addr; // Slave address config.
        logic [7:0] ctrl; // Bus control.
        logic [7:0] stat; // Status code.
        logic [7:0] data; // Data register.
        logic [7:0] shift; // Shift register.
        logic [3:0] cnt; // Bit counter.
        logic rd; // Current transfer is a read.
        logic last; // Byte in flight is the last one.
        logic arb; // Arbitration was lost.
        logic wake; // Woken from sleep by match.
        logic sda_low; // Pull data low.
        logic [1:0] irqs; // Sticky events: flag, stop.
        logic [1:0] irqm; // Event mask.
    } twsl_st_t;
    twsl_st_t st_ff;
    twsl_st_t nxt_st;
    twsl_pkg::twsl_bus_ev_t ev; // Synchronised bus events.
    logic wr_acc; // APB write access.
    logic rd_hit; // Address maps to a register.
    logic flag_clr; // Software writes one to the flag.

    // Line synchroniser and event decoder.
    twsl_sync u_sync (
        .CLK(CLK),
        .RST(RST),
        .scl_i(SCL_I),
        .sda_i(SDA_I),
        .ev(ev)
    );

    // Decodes a byte address to a register hit; used twice.
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `TWSL_OFF_ADDR) || (a == `TWSL_OFF_CTRL) ||
            (a == `TWSL_OFF_STAT) || (a == `TWSL_OFF_DATA) ||
            (a == `TWSL_OFF_IRQS) || (a == `TWSL_OFF_IRQM);
    endfunction : is_mapped

    assign wr_acc = PSEL & PENABLE & PWRITE & is_mapped(PADDR);
    assign rd_hit = is_mapped(PADDR);
    assign flag_clr = wr_acc && (PADDR == `TWSL_OFF_CTRL) && PWDATA[`TWSL_CTL_FLAG];

    // ----------------------------------------------------------------
    // Next state: register writes, then the bus engine.
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Register writes take effect in the access phase.
        if (wr_acc) begin
            case (PADDR)
                `TWSL_OFF_ADDR: begin
                    nxt_st.addr = PWDATA[7:0];
                end
                `TWSL_OFF_CTRL: begin
                    // Flag is write-one-to-clear; collision bit is read only.
                    nxt_st.ctrl = {st_ff.ctrl[7], PWDATA[6:4], st_ff.ctrl[3], PWDATA[2:0]};
                    if (PWDATA[`TWSL_CTL_FLAG]) begin
                        nxt_st.ctrl[`TWSL_CTL_FLAG] = 1'b0;
                    end
                end
                `TWSL_OFF_DATA: begin
                    // Writing while the flag is low is a collision.
                    if (st_ff.ctrl[`TWSL_CTL_FLAG]) begin
                        nxt_st.data = PWDATA[7:0];
                    end else begin
                        nxt_st.ctrl[`TWSL_CTL_WCOL] = 1'b1;
                    end
                end
                `TWSL_OFF_IRQS: begin
                    nxt_st.irqs = st_ff.irqs & ~PWDATA[1:0];
                end
                `TWSL_OFF_IRQM: begin
                    nxt_st.irqm = PWDATA[1:0];
                end
                default: begin
                end
            endcase
        end
        if (ARB_LOST) begin
            nxt_st.arb = 1'b1;
        end
        // Status reads F8 while no service is pending.
        if (flag_clr) begin
            nxt_st.stat = `TWSL_ST_NONE;
        end
        if (!st_ff.ctrl[`TWSL_CTL_EN]) begin
            nxt_st.fsm = twsl_pkg::S_IDLE;
            nxt_st.sda_low = 1'b0;
        end else if ((ev.stop || ev.start) && st_ff.fsm != twsl_pkg::S_IDLE) begin
            // Stop while addressed
            // A start also begins a new address; A0 only if addressed.
            if (st_ff.fsm != twsl_pkg::S_ADDR && st_ff.fsm != twsl_pkg::S_LAST) begin
                nxt_st.stat = `TWSL_ST_STOP;
                nxt_st.ctrl[`TWSL_CTL_FLAG] = 1'b1;
                nxt_st.irqs[1] = 1'b1;
            end
            nxt_st.fsm = ev.start ? twsl_pkg::S_ADDR : twsl_pkg::S_IDLE;
            nxt_st.cnt = 4'h0;
            nxt_st.sda_low = 1'b0;
        end else begin
            case (st_ff.fsm)
                twsl_pkg::S_IDLE: begin
                    if (ev.start) begin
                        nxt_st.fsm = twsl_pkg::S_ADDR;
                        nxt_st.cnt = 4'h0;
                    end
                end
                twsl_pkg::S_ADDR: begin
                    if (ev.scl_rise) begin
                        nxt_st.shift = {st_ff.shift[6:0], ev.sda};
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end
                    if (ev.scl_fall && st_ff.cnt == 4'h8) begin
                        if (st_ff.ctrl[`TWSL_CTL_ACK] &&
                            ((st_ff.shift[7:1] == st_ff.addr[7:1]) ||
                             (st_ff.addr[0] && st_ff.shift[7:1] == `TWSL_GC_ADDR))) begin
                            nxt_st.fsm = twsl_pkg::S_AACK;
                            nxt_st.sda_low = 1'b1;
                            nxt_st.rd = st_ff.shift[0];
                        end else begin
                            nxt_st.fsm = twsl_pkg::S_IDLE;
                        end
                    end
                end
                twsl_pkg::S_AACK: begin
                    if (ev.scl_fall) begin
                        nxt_st.sda_low = 1'b0;
                        nxt_st.ctrl[`TWSL_CTL_FLAG] = 1'b1;
                        nxt_st.irqs[0] = 1'b1;
                        // Wake the system after sleep match
                        nxt_st.wake = st_ff.ctrl[`TWSL_CTL_SLEEP];
                        if (st_ff.rd) begin
                            nxt_st.stat = st_ff.arb ? `TWSL_ST_ARBR : `TWSL_ST_SLAR;
                            nxt_st.fsm = twsl_pkg::S_HOLD;
                        end else begin
                            nxt_st.stat = (st_ff.shift[7:1] == `TWSL_GC_ADDR) ?
                                `TWSL_ST_GCW : `TWSL_ST_SLAW;
                            nxt_st.fsm = twsl_pkg::S_RX;
                        end
                        nxt_st.arb = 1'b0;
                    end
                end
                twsl_pkg::S_HOLD: begin
                    if (flag_clr) begin
                        nxt_st.last = ~PWDATA[`TWSL_CTL_ACK];
                        nxt_st.wake = 1'b0;
                        nxt_st.shift = st_ff.data;
                        nxt_st.cnt = 4'h0;
                        nxt_st.sda_low = ~st_ff.data[7];
                        nxt_st.fsm = twsl_pkg::S_TXB;
                    end
                end
                twsl_pkg::S_TXB: begin
                    if (ev.scl_fall) begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                        if (st_ff.cnt == 4'h7) begin
                            nxt_st.sda_low = 1'b0;
                            nxt_st.fsm = twsl_pkg::S_RACK;
                        end else begin
                            nxt_st.shift = {st_ff.shift[6:0], 1'b1};
                            nxt_st.sda_low = ~st_ff.shift[6];
                        end
                    end
                end
                twsl_pkg::S_RACK: begin
                    // The acknowledge is kept in the spare shift bit on the rise.
                    if (ev.scl_rise) begin
                        nxt_st.shift[0] = ev.sda;
                    end
                    // Flag and stretch wait for the fall, so the clock is never pulled low while high.
                    if (ev.scl_fall) begin
                        nxt_st.ctrl[`TWSL_CTL_FLAG] = 1'b1;
                        nxt_st.irqs[0] = 1'b1;
                        // C0 on NACK; on ACK, C8 for the last byte, else B8
                        if (st_ff.last) begin
                            nxt_st.stat = st_ff.shift[0] ? `TWSL_ST_DNAK : `TWSL_ST_LACK;
                            nxt_st.fsm = twsl_pkg::S_LAST;
                        end else begin
                            nxt_st.stat = st_ff.shift[0] ? `TWSL_ST_DNAK : `TWSL_ST_DACK;
                            nxt_st.fsm = st_ff.shift[0] ? twsl_pkg::S_LAST : twsl_pkg::S_HOLD;
                        end
                    end
                end
                twsl_pkg::S_LAST: begin
                    nxt_st.sda_low = 1'b0;
                end
                twsl_pkg::S_RX: begin
                    // Receive data path is not served; the bus stays released.
                    nxt_st.sda_low = 1'b0;
                end
                default: begin
                    nxt_st.fsm = twsl_pkg::S_IDLE;
                end
            endcase
        end
        // Hardware set wins over a same-cycle software clear.
        if (st_ff.ctrl[`TWSL_CTL_FLAG] && !flag_clr) begin
            nxt_st.ctrl[`TWSL_CTL_FLAG] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register.
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_ff <= '0;
            st_ff.addr <= `TWSL_RST_ADDR;
            st_ff.ctrl <= `TWSL_RST_CTRL;
            st_ff.stat <= `TWSL_ST_NONE;
            st_ff.fsm <= twsl_pkg::S_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs. Data reads may be stale after a wake-up.
    // ----------------------------------------------------------------
    // Data register not refreshed on wake
    always_comb begin
        PRDATA = 32'h0000_0000;
        case (PADDR)
            `TWSL_OFF_ADDR: PRDATA[7:0] = st_ff.addr;
            `TWSL_OFF_CTRL: PRDATA[7:0] = st_ff.ctrl;
            `TWSL_OFF_STAT: PRDATA[7:0] = {st_ff.stat[7:3], 3'b000};
            `TWSL_OFF_DATA: PRDATA[7:0] = st_ff.data;
            `TWSL_OFF_IRQS: PRDATA[1:0] = st_ff.irqs;
            `TWSL_OFF_IRQM: PRDATA[1:0] = st_ff.irqm;
            default: PRDATA = 32'h0000_0000;
        endcase
    end
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~rd_hit;
    // Hold clock low while flag set in S_HOLD
    assign SCL_OE = st_ff.ctrl[`TWSL_CTL_FLAG] && (st_ff.fsm == twsl_pkg::S_HOLD);
    assign SCL_O = 1'b0;
    assign SDA_OE = st_ff.sda_low;
    assign SDA_O = 1'b0;
    assign WAKE = st_ff.wake;
    assign IRQ = |(st_ff.irqs & st_ff.irqm);

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    chk_clock_stretch: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.fsm == twsl_pkg::S_HOLD && st_ff.ctrl[7]) |-> SCL_OE)
        else $error("clock not held while flag set");
    chk_stop_code: assert property (@(posedge CLK) disable iff (RST)
        (ev.stop && st_ff.ctrl[2] && st_ff.fsm inside {twsl_pkg::S_HOLD, twsl_pkg::S_TXB,
            twsl_pkg::S_RACK, twsl_pkg::S_RX})
        |=> (st_ff.stat == 8'hA0 && st_ff.ctrl[7]))
        else $error("stop while addressed did not report A0");
    chk_last_release: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.fsm == twsl_pkg::S_LAST) |=> !SDA_OE)
        else $error("data line driven after final byte");
    chk_read_entry: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.fsm == twsl_pkg::S_AACK && ev.scl_fall && st_ff.rd && st_ff.ctrl[2])
        |=> (st_ff.fsm == twsl_pkg::S_HOLD && (st_ff.stat == 8'hA8 || st_ff.stat == 8'hB0)))
        else $error("read address did not enter transmit");
    chk_nack_gate: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.fsm == twsl_pkg::S_ADDR && !st_ff.ctrl[6] && !ev.start && !ev.stop)
        |=> st_ff.fsm != twsl_pkg::S_AACK)
        else $error("address acknowledged while disabled");
    chk_stat_low: assert property (@(posedge CLK) disable iff (RST)
        (PADDR == `TWSL_OFF_STAT) |-> PRDATA[2:0] == 3'b000)
        else $error("status prescaler bits not zero");
    chk_irq_level: assert property (@(posedge CLK) disable iff (RST)
        IRQ == |(st_ff.irqs & st_ff.irqm))
        else $error("interrupt level mismatch");
    chk_stretch_low: assert property (@(posedge CLK) disable iff (RST)
        $rose(SCL_OE) |-> !$past(SCL_I))
        else $error("clock pulled low while the line was high");
    chk_final_code: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.fsm == twsl_pkg::S_RACK && st_ff.last && ev.scl_fall && st_ff.ctrl[2])
        |=> (st_ff.fsm == twsl_pkg::S_LAST && (st_ff.stat == 8'hC0 || st_ff.stat == 8'hC8)))
        else $error("final byte did not report C0 or C8");
    chk_wake_set: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.fsm == twsl_pkg::S_AACK && ev.scl_fall && st_ff.ctrl[1] && st_ff.ctrl[2])
        |=> WAKE)
        else $error("no wake request after a match in sleep");
endmodule : twsl_slave

// ===== twsl_mst_model.sv
// Purpose: Master receiver model for the two-wire slave bench.
// Assumes: Open-drain lines with pull-ups resolved in the bench.
// Notes: A half bit is 8 CLK; with the data delay the bus clock period is 19 CLK, 190 ns.
`timescale 1ns/10ps
module twsl_mst_model (
    input wire logic CLK, // System clock.
    input wire logic scl_i, // Resolved clock line.
    input wire logic sda_i, // Resolved data line.
    output logic scl_oe, // High while pulling clock low.
    output logic sda_oe // High while pulling data low.
);
    int n_hang = 0; // Clock waits that ran out.
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // Wait one half bit.
    task automatic half();
        repeat (8) @(posedge CLK);
    endtask : half
    // Release the clock, then honour any stretch for a bounded time.
    task automatic rise();
        int k;
        k = 0;
        scl_oe <= 1'b0;
        @(posedge CLK);
        while (!scl_i && k < 5000) begin
            @(posedge CLK);
            k++;
        end
        if (k >= 5000) n_hang++;
        half();
    endtask : rise
    // One bit; data moves two CLK after the fall so it never races the clock.
    task automatic bit_io(input logic b, output logic got);
        repeat (2) @(posedge CLK);
        sda_oe <= !b;
        half();
        rise();
        got = sda_i;
        scl_oe <= 1'b1;
    endtask : bit_io
    // Start condition from an idle bus.
    task automatic start();
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b1;
        half();
    endtask : start
    // Stop condition, entered with the clock low.
    task automatic stop();
        repeat (2) @(posedge CLK);
        sda_oe <= 1'b1;
        half();
        rise();
        sda_oe <= 1'b0;
        half();
    endtask : stop
    task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                        output logic ack_seen);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], b);
            rx[i] = b;
        end
        bit_io(ack, ack_seen);
    endtask : xfer
endmodule : twsl_mst_model

// ===== tb_two_wire_slave_transmitter.sv
// Purpose: Self-checking bench for the two-wire slave transmitter.
// Assumes: APB master here, master receiver model on the bus.
// Notes: Lines resolve as open drain with pull-ups.
`timescale 1ns/10ps
`include "twsl_map.svh"
module tb_two_wire_slave_transmitter;
    localparam logic [31:0] C_RUN = 32'h0000_0045; // Enable, ack, irq enable.
    localparam logic [31:0] C_GO = 32'h0000_00C5; // Same, clearing the flag.
    localparam logic [31:0] C_LAST = 32'h0000_0085; // Clear flag, ack off.
    logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000; // APB address.
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA; // APB data.
    logic PREADY, PSLVERR, ARB_LOST = 1'b0, SCL_I, SDA_I; // Bus inputs and answers.
    logic SCL_OE, SDA_OE, SCL_O, SDA_O, WAKE, IRQ, m_scl_oe, m_sda_oe; // Line pulls.
    logic [31:0] q; // Last read word.
    logic [7:0] rx; // Last byte from the bus.
    logic ak, se; // Last acknowledge and last bus error.
    int err_total = 0; // Mismatches.
    int n_tests = 0; // Comparisons.
    // A line is low while any party pulls it.
    assign SCL_I = !(SCL_OE || m_scl_oe);
    assign SDA_I = !(SDA_OE || m_sda_oe);
    always #5 CLK = ~CLK;
    twsl_slave i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .ARB_LOST(ARB_LOST), .SCL_I(SCL_I), .SCL_OE(SCL_OE), .SCL_O(SCL_O), .SDA_I(SDA_I),
        .SDA_OE(SDA_OE), .SDA_O(SDA_O), .WAKE(WAKE), .IRQ(IRQ));
    twsl_mst_model i_mst (.CLK(CLK), .scl_i(SCL_I), .sda_i(SDA_I), .scl_oe(m_scl_oe),
        .sda_oe(m_sda_oe));
    // A clock stretch that never ends stops the run at once.
    always @(posedge CLK) begin
        if (i_mst.n_hang != 0) begin
            final_report();
        end
    end
    // Verdict and end of run.
    task automatic final_report();
        err_total += i_mst.n_hang;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask : chk1
    // One APB transfer; the idle cycle after it keeps each strobe to one change a step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        q = PRDATA;
        se = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
        if (k >= 50) begin
            err_total++;
            final_report();
        end
    endtask : apb
    // Poll the control word until the service flag is up.
    task automatic wait_flag();
        int k;
        k = 0;
        do begin
            apb(1'b0, `TWSL_OFF_CTRL, 32'h0000_0000);
            k++;
        end while (q[`TWSL_CTL_FLAG] !== 1'b1 && k < 400);
        if (k >= 400) begin
            err_total++;
            final_report();
        end
    endtask : wait_flag
    // Address the slave and check the acknowledge and the status.
    task automatic own_rd(input logic [7:0] ad, input logic [7:0] st);
        i_mst.start();
        i_mst.xfer(ad, 1'b1, rx, ak);
        chk1("address ack", 1'b0, ak);
        wait_flag();
        apb(1'b0, `TWSL_OFF_STAT, 32'h0000_0000);
        chk8("status", st, q[7:0]);
    endtask : own_rd
    // Stop while still addressed, then serve the stop status.
    task automatic quit();
        apb(1'b1, `TWSL_OFF_DATA, 32'h0000_00FF);
        apb(1'b1, `TWSL_OFF_CTRL, C_GO);
        i_mst.stop();
        wait_flag();
        apb(1'b0, `TWSL_OFF_STAT, 32'h0000_0000);
        chk8("stop status", `TWSL_ST_STOP, q[7:0]);
        apb(1'b1, `TWSL_OFF_CTRL, C_GO);
    endtask : quit
    initial begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        apb(1'b0, `TWSL_OFF_ADDR, 32'h0);
        chk8("addr reset", `TWSL_RST_ADDR, q[7:0]);
        apb(1'b0, `TWSL_OFF_CTRL, 32'h0);
        chk8("ctrl reset", `TWSL_RST_CTRL, q[7:0]);
        apb(1'b0, `TWSL_OFF_STAT, 32'h0);
        chk8("idle status", `TWSL_ST_NONE, q[7:0]);
        apb(1'b0, 12'h018, 32'h0);
        chk1("unmapped error", 1'b1, se);
        apb(1'b1, `TWSL_OFF_ADDR, 32'h0000_0055);
        apb(1'b1, `TWSL_OFF_CTRL, C_RUN);
        apb(1'b1, `TWSL_OFF_IRQM, 32'h0000_0001);
        own_rd(8'h55, `TWSL_ST_SLAR);
        chk1("clock held", 1'b1, SCL_OE);
        chk1("irq raised", 1'b1, IRQ);
        apb(1'b1, `TWSL_OFF_IRQM, 32'h0000_0000);
        chk1("irq masked", 1'b0, IRQ);
        apb(1'b1, `TWSL_OFF_IRQM, 32'h0000_0001);
        apb(1'b1, `TWSL_OFF_IRQS, 32'h0000_0001);
        chk1("irq cleared", 1'b0, IRQ);
        apb(1'b1, `TWSL_OFF_DATA, 32'h0000_00A5);
        apb(1'b1, `TWSL_OFF_CTRL, C_GO);
        i_mst.xfer(8'hFF, 1'b0, rx, ak);
        chk8("data byte", 8'hA5, rx);
        wait_flag();
        apb(1'b0, `TWSL_OFF_STAT, 32'h0);
        chk8("acked status", `TWSL_ST_DACK, q[7:0]);
        apb(1'b1, `TWSL_OFF_DATA, 32'h0000_003C);
        apb(1'b1, `TWSL_OFF_CTRL, C_LAST);
        i_mst.xfer(8'hFF, 1'b0, rx, ak);
        chk8("last byte", 8'h3C, rx);
        wait_flag();
        apb(1'b0, `TWSL_OFF_STAT, 32'h0);
        chk8("last acked", `TWSL_ST_LACK, q[7:0]);
        apb(1'b1, `TWSL_OFF_CTRL, C_GO);
        i_mst.xfer(8'hFF, 1'b0, rx, ak);
        chk8("released data", 8'hFF, rx);
        i_mst.stop();
        own_rd(8'h55, `TWSL_ST_SLAR);
        apb(1'b1, `TWSL_OFF_DATA, 32'h0000_0081);
        apb(1'b1, `TWSL_OFF_CTRL, C_LAST);
        i_mst.xfer(8'hFF, 1'b1, rx, ak);
        chk8("final byte", 8'h81, rx);
        wait_flag();
        apb(1'b0, `TWSL_OFF_STAT, 32'h0);
        chk8("last nacked", `TWSL_ST_DNAK, q[7:0]);
        apb(1'b1, `TWSL_OFF_CTRL, C_GO);
        i_mst.stop();
        own_rd(8'h00, `TWSL_ST_GCW);
        quit();
        apb(1'b1, `TWSL_OFF_ADDR, 32'h0000_0054);
        i_mst.start();
        i_mst.xfer(8'h00, 1'b1, rx, ak);
        chk1("call ignored", 1'b1, ak);
        i_mst.stop();
        apb(1'b1, `TWSL_OFF_CTRL, 32'h0000_0005);
        i_mst.start();
        i_mst.xfer(8'h55, 1'b1, rx, ak);
        chk1("ack disabled", 1'b1, ak);
        i_mst.stop();
        apb(1'b1, `TWSL_OFF_CTRL, C_RUN);
        ARB_LOST <= 1'b1;
        @(posedge CLK);
        ARB_LOST <= 1'b0;
        own_rd(8'h55, `TWSL_ST_ARBR);
        quit();
        apb(1'b1, `TWSL_OFF_CTRL, 32'h0000_0047);
        own_rd(8'h55, `TWSL_ST_SLAR);
        chk1("wake raised", 1'b1, WAKE);
        chk1("wake clock held", 1'b1, SCL_OE);
        quit();
        chk1("wake dropped", 1'b0, WAKE);
        final_report();
    end
endmodule : tb_two_wire_slave_transmitter
